// [fdlsm_regs.sv]
// Data-link controller status, interrupt mask and receive-read register set
`timescale 1ns/1ps
`default_nettype none
module fdlsm_regs
  import fdlsm_pkg::*;
#(
  parameter int RX_DEPTH = FDLSM_RX_DEPTH
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  // Host control port
  input  wire logic [7:0]              host_addr,
  input  wire logic                    host_wr,
  input  wire logic                    host_rd,
  input  wire logic [7:0]              host_wdata,
  output logic      [7:0]              host_rdata,
  output logic                         irq,
  // Receive bit stream from the link deframer
  input  wire logic                    rx_bit_strobe,
  input  wire logic                    rx_bit,
  // Received bytes from the receive controller
  input  wire logic                    rx_byte_valid,
  input  wire logic [7:0]              rx_byte,
  input  wire logic                    rx_byte_first,
  input  wire logic                    rx_byte_last,
  input  wire logic                    rx_crc_ok,
  // Bit-oriented code detector
  input  wire logic                    code_detect,
  input  wire logic                    code_valid,
  input  wire logic [FDLSM_CODE_W-1:0] code_word,
  // Transmit side
  input  wire logic                    tx_fifo_empty,
  input  wire logic                    tx_fifo_full,
  input  wire logic                    tx_fifo_half_empty,
  input  wire logic                    tx_in_message,
  input  wire logic                    tx_byte_req,
  input  wire logic                    tx_msg_done,
  output logic                         tx_abort
);

  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam int FW = 8 + FDLSM_TAG_W;

  initial begin
    if (RX_DEPTH < 2) begin
      $error("fdlsm_regs: RX_DEPTH too small");
    end
  end

  typedef struct packed {
    logic [7:0]              mask;
    logic                    code_chg;
    logic                    pkt_end;
    logic                    pkt_start;
    logic                    tx_end;
    logic                    abort_seen;
    logic                    crc_err;
    logic                    rx_ovr;
    logic                    good_msg;
    logic                    code_latched;
    logic                    code_live;
    logic [FDLSM_CODE_W-1:0] code;
    logic                    tx_udr;
    logic                    tx_abort;
    logic [2:0]              ones_cnt;
    logic                    pkt_bad;
    logic [7:0]              rdata;
  } fdlsm_state_t;

  fdlsm_state_t s_reg;
  fdlsm_state_t s_next;

  // Receive FIFO wiring
  logic          fifo_push;
  logic [FW-1:0] fifo_wdata;
  logic          fifo_pop;
  logic [FW-1:0] fifo_head;
  logic          fifo_empty;
  logic          fifo_full;
  logic [CW-1:0] fifo_count;

  // Decoded accesses
  logic rd_link;
  logic rd_pkt;
  logic rd_code;
  logic rd_fifo;
  logic rd_tx;
  logic wr_mask;

  // Events
  logic ev_abort;
  logic ev_ovr;
  logic ev_last;
  logic ev_first;
  logic ev_udr;
  logic tag_good;

  // Assembled register images
  logic [7:0] link_status;
  logic [7:0] pkt_status;
  logic [7:0] code_status;
  logic [7:0] tx_status;

  assign rd_link = host_rd && (host_addr == FDLSM_OFS_LINK_STATUS);
  assign rd_pkt  = host_rd && (host_addr == FDLSM_OFS_PKT_STATUS);
  assign rd_code = host_rd && (host_addr == FDLSM_OFS_CODE_STATUS);
  assign rd_fifo = host_rd && (host_addr == FDLSM_OFS_RX_FIFO);
  assign rd_tx   = host_rd && (host_addr == FDLSM_OFS_TX_STATUS);
  assign wr_mask = host_wr && (host_addr == FDLSM_OFS_EVENT_MASK);

  // Seventh one in a row, or any further one while the run lasts
  assign ev_abort = rx_bit_strobe && rx_bit
                    && (s_reg.ones_cnt >= (FDLSM_ABORT_ONES - 3'h1));
  assign ev_ovr   = rx_byte_valid && fifo_full;
  assign ev_last  = rx_byte_valid && rx_byte_last;
  assign ev_first = rx_byte_valid && rx_byte_first;
  assign ev_udr   = tx_byte_req && tx_in_message && tx_fifo_empty;

  // Last byte is good only if nothing went wrong anywhere in the packet
  assign tag_good = rx_crc_ok && !ev_abort && !ev_ovr && (rx_byte_first || !s_reg.pkt_bad);

  assign fifo_push  = rx_byte_valid && !fifo_full;
  assign fifo_pop   = rd_fifo;
  assign fifo_wdata = {rx_byte, tag_good && rx_byte_last, rx_byte_last, rx_byte_first};

  fdlsm_rx_fifo #(
    .WIDTH (FW),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .push      (fifo_push),
    .push_data (fifo_wdata),
    .pop       (fifo_pop),
    .head_data (fifo_head),
    .empty     (fifo_empty),
    .full      (fifo_full),
    .count     (fifo_count)
  );

  always_comb begin
    link_status                     = '0;
    link_status[FDLSM_EV_CODE_CHG]  = s_reg.code_chg;
    link_status[FDLSM_EV_PKT_END]   = s_reg.pkt_end;
    link_status[FDLSM_EV_PKT_START] = s_reg.pkt_start;
    link_status[FDLSM_EV_RX_HALF]   = (fifo_count > CW'(RX_DEPTH / 2));
    link_status[FDLSM_EV_RX_NE]     = !fifo_empty;
    link_status[FDLSM_EV_TX_HALF]   = tx_fifo_half_empty;
    link_status[FDLSM_EV_TX_NF]     = !tx_fifo_full;
    link_status[FDLSM_EV_TX_END]    = s_reg.tx_end;
  end

  always_comb begin
    pkt_status                 = '0;
    pkt_status[FDLSM_PK_ABORT] = s_reg.abort_seen;
    pkt_status[FDLSM_PK_CRC]   = s_reg.crc_err;
    pkt_status[FDLSM_PK_OVR]   = s_reg.rx_ovr;
    pkt_status[FDLSM_PK_VALID] = s_reg.good_msg;
    pkt_status[FDLSM_PK_EMPTY] = fifo_empty;
    // Position tags travel with each byte and show for the head byte
    pkt_status[FDLSM_PK_GOOD]  = !fifo_empty && fifo_head[2];
    pkt_status[FDLSM_PK_CLOSE] = !fifo_empty && fifo_head[1];
    pkt_status[FDLSM_PK_OPEN]  = !fifo_empty && fifo_head[0];
  end

  always_comb begin
    code_status                                = '0;
    code_status[FDLSM_CD_LATCHED]              = s_reg.code_latched;
    code_status[FDLSM_CD_LIVE]                 = s_reg.code_live;
    code_status[FDLSM_CODE_W-1:0]              = s_reg.code;
  end

  always_comb begin
    tx_status                 = '0;
    tx_status[FDLSM_TX_EMPTY] = tx_fifo_empty;
    tx_status[FDLSM_TX_FULL]  = tx_fifo_full;
    tx_status[FDLSM_TX_UDR]   = s_reg.tx_udr;
  end

  always_comb begin
    s_next = s_reg;

    if (wr_mask) begin
      s_next.mask = host_wdata;
    end

    // Ones run counter on the raw receive stream
    if (rx_bit_strobe) begin
      if (!rx_bit) begin
        s_next.ones_cnt = '0;
      end else if (s_reg.ones_cnt != FDLSM_ABORT_ONES) begin
        s_next.ones_cnt = s_reg.ones_cnt + 3'h1;
      end
    end

    // Packet fault memory, restarted by each opening byte
    if (ev_first) begin
      s_next.pkt_bad = ev_ovr || ev_abort;
    end else if (ev_ovr || ev_abort) begin
      s_next.pkt_bad = 1'b1;
    end
    if (ev_last && !ev_first) begin
      s_next.pkt_bad = 1'b0;
    end

    // Read clears first, then new events win
    if (rd_link) begin
      s_next.code_chg  = 1'b0;
      s_next.pkt_end   = 1'b0;
      s_next.pkt_start = 1'b0;
      s_next.tx_end    = 1'b0;
    end
    if (rd_pkt) begin
      s_next.abort_seen = 1'b0;
      s_next.crc_err    = 1'b0;
      s_next.rx_ovr     = 1'b0;
      s_next.good_msg   = 1'b0;
    end
    if (rd_code) begin
      s_next.code_latched = 1'b0;
    end
    if (rd_tx) begin
      s_next.tx_udr = 1'b0;
    end

    if (ev_abort) begin
      s_next.abort_seen = 1'b1;
      s_next.pkt_end    = 1'b1;
    end
    if (ev_last && !rx_crc_ok) begin
      s_next.crc_err = 1'b1;
    end
    if (ev_ovr) begin
      s_next.rx_ovr  = 1'b1;
      s_next.pkt_end = 1'b1;
    end
    if (ev_last) begin
      s_next.good_msg = 1'b1;
      s_next.pkt_end  = 1'b1;
    end
    if (ev_first) begin
      s_next.pkt_start = 1'b1;
    end
    if (tx_msg_done) begin
      s_next.tx_end = 1'b1;
    end

    // Code detector
    s_next.code_live = code_detect;
    if (code_detect != s_reg.code_live) begin
      s_next.code_chg = 1'b1;
    end
    if (code_detect) begin
      s_next.code_latched = 1'b1;
    end
    if (code_valid) begin
      s_next.code = code_word;
    end

    // Underflow: flag plus a one-cycle abort request to the transmitter
    s_next.tx_abort = ev_udr;
    if (ev_udr) begin
      s_next.tx_udr = 1'b1;
    end

    // Read data captured from the pre-clear images
    if (host_rd) begin
      case (host_addr)
        FDLSM_OFS_LINK_STATUS: s_next.rdata = link_status;
        FDLSM_OFS_EVENT_MASK:  s_next.rdata = s_reg.mask;
        FDLSM_OFS_PKT_STATUS:  s_next.rdata = pkt_status;
        FDLSM_OFS_CODE_STATUS: s_next.rdata = code_status;
        FDLSM_OFS_RX_FIFO:     s_next.rdata = fifo_head[FW-1:FDLSM_TAG_W];
        FDLSM_OFS_TX_STATUS:   s_next.rdata = tx_status;
        default:               s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg      <= '0;
      s_reg.mask <= FDLSM_RST_MASK;
      s_reg.code <= FDLSM_RST_CODE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign host_rdata = s_reg.rdata;
  assign tx_abort   = s_reg.tx_abort;
  assign irq        = |(link_status & s_reg.mask);

endmodule
`default_nettype wire

// [fdlsm_pkg.sv]
// Shared constants of the data-link status, mask and receive-read register set
package fdlsm_pkg;

  // Register offsets on the parallel control port
  localparam logic [7:0] FDLSM_OFS_LINK_STATUS = 8'h01;
  localparam logic [7:0] FDLSM_OFS_EVENT_MASK  = 8'h02;
  localparam logic [7:0] FDLSM_OFS_PKT_STATUS  = 8'h03;
  localparam logic [7:0] FDLSM_OFS_CODE_STATUS = 8'h04;
  localparam logic [7:0] FDLSM_OFS_RX_FIFO     = 8'h05;
  localparam logic [7:0] FDLSM_OFS_TX_STATUS   = 8'h06;

  // Event status and mask bit positions
  localparam int FDLSM_EV_CODE_CHG  = 7;
  localparam int FDLSM_EV_PKT_END   = 6;
  localparam int FDLSM_EV_PKT_START = 5;
  localparam int FDLSM_EV_RX_HALF   = 4;
  localparam int FDLSM_EV_RX_NE     = 3;
  localparam int FDLSM_EV_TX_HALF   = 2;
  localparam int FDLSM_EV_TX_NF     = 1;
  localparam int FDLSM_EV_TX_END    = 0;

  // Receive packet status bit positions
  localparam int FDLSM_PK_ABORT  = 7;
  localparam int FDLSM_PK_CRC    = 6;
  localparam int FDLSM_PK_OVR    = 5;
  localparam int FDLSM_PK_VALID  = 4;
  localparam int FDLSM_PK_EMPTY  = 3;
  localparam int FDLSM_PK_GOOD   = 2;
  localparam int FDLSM_PK_CLOSE  = 1;
  localparam int FDLSM_PK_OPEN   = 0;

  // Receive code status bit positions
  localparam int FDLSM_CD_LATCHED = 7;
  localparam int FDLSM_CD_LIVE    = 6;
  localparam int FDLSM_CODE_W     = 6;

  // Transmit status bit positions
  localparam int FDLSM_TX_EMPTY = 2;
  localparam int FDLSM_TX_FULL  = 1;
  localparam int FDLSM_TX_UDR   = 0;

  // Reset values and counts
  localparam logic [7:0] FDLSM_RST_MASK = 8'h00;
  localparam logic [5:0] FDLSM_RST_CODE = 6'h3F;
  localparam logic [2:0] FDLSM_ABORT_ONES = 3'h7;
  localparam int FDLSM_RX_DEPTH = 16;
  localparam int FDLSM_TAG_W    = 3;

endpackage

// [fdlsm_rx_fifo.sv]
// Receive byte FIFO carrying a position tag with each byte
`timescale 1ns/1ps
`default_nettype none
module fdlsm_rx_fifo
  import fdlsm_pkg::*;
#(
  parameter int WIDTH = 8 + FDLSM_TAG_W,
  parameter int DEPTH = FDLSM_RX_DEPTH
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // Write side
  input  wire logic                       push,
  input  wire logic [WIDTH-1:0]           push_data,
  // Read side
  input  wire logic                       pop,
  output logic      [WIDTH-1:0]           head_data,
  // Fill level
  output logic                            empty,
  output logic                            full,
  output logic      [$clog2(DEPTH+1)-1:0] count
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("fdlsm_rx_fifo: DEPTH must be a power of two >= 2");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
  } fdlsm_fifo_state_t;

  fdlsm_fifo_state_t s_reg;
  fdlsm_fifo_state_t s_next;
  logic              do_push;
  logic              do_pop;

  assign empty     = (s_reg.count == '0);
  assign full      = (s_reg.count == CW'(DEPTH));
  assign count     = s_reg.count;
  assign head_data = s_reg.mem[s_reg.rd_ptr];
  assign do_push   = push && !full;
  assign do_pop    = pop && !empty;

  always_comb begin
    s_next = s_reg;
    if (do_push) begin
      s_next.mem[s_reg.wr_ptr] = push_data;
      s_next.wr_ptr            = s_reg.wr_ptr + AW'(1);
    end
    if (do_pop) begin
      s_next.rd_ptr = s_reg.rd_ptr + AW'(1);
    end
    case ({do_push, do_pop})
      2'b10:   s_next.count = s_reg.count + CW'(1);
      2'b01:   s_next.count = s_reg.count - CW'(1);
      default: s_next.count = s_reg.count;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule
`default_nettype wire

// [fdlsm_regs_checker.sv]
// Port-level assertions for the data-link status and mask register set
`timescale 1ns/1ps
`default_nettype none
module fdlsm_regs_checker
  import fdlsm_pkg::*;
(
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    arst_n,
  // Host control port
  input wire logic [7:0]              host_addr,
  input wire logic                    host_wr,
  input wire logic                    host_rd,
  input wire logic [7:0]              host_wdata,
  input wire logic [7:0]              host_rdata,
  input wire logic                    irq,
  // Receive side
  input wire logic                    rx_bit_strobe,
  input wire logic                    rx_bit,
  input wire logic                    rx_byte_valid,
  input wire logic [7:0]              rx_byte,
  input wire logic                    rx_byte_first,
  input wire logic                    rx_byte_last,
  input wire logic                    rx_crc_ok,
  // Code detector
  input wire logic                    code_detect,
  input wire logic                    code_valid,
  input wire logic [FDLSM_CODE_W-1:0] code_word,
  // Transmit side
  input wire logic                    tx_fifo_empty,
  input wire logic                    tx_fifo_full,
  input wire logic                    tx_fifo_half_empty,
  input wire logic                    tx_in_message,
  input wire logic                    tx_byte_req,
  input wire logic                    tx_msg_done,
  input wire logic                    tx_abort
);
  logic [7:0] mask_reg;
  logic [5:0] code_reg;
  logic       tx_underflow_flag;
  logic       quiet;
  assign tx_underflow_flag   = tx_byte_req && tx_in_message && tx_fifo_empty;
  assign quiet = !rx_byte_valid && !rx_bit_strobe;
  // Shadows of the mask and of the last verified code
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= FDLSM_RST_MASK;
      code_reg <= FDLSM_RST_CODE;
    end else begin
      if (host_wr && host_addr == 8'h02) mask_reg <= host_wdata;
      if (code_valid) code_reg <= code_word;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  tx_udr_a: assert property (tx_underflow_flag |=> tx_abort)
    else $error("no abort after underflow");
  tx_pulse_a: assert property (tx_underflow_flag ##1 !tx_underflow_flag |=> !tx_abort)
    else $error("abort pulse too long");
  tx_live_a: assert property (host_rd && host_addr == 8'h06 |=>
    host_rdata[2] == $past(tx_fifo_empty) && host_rdata[1] == $past(tx_fifo_full))
    else $error("transmit levels wrong");
  udr_clear_a: assert property (host_rd && host_addr == 8'h06 && !tx_underflow_flag ##1 !tx_underflow_flag
    ##1 host_rd && host_addr == 8'h06 && !tx_underflow_flag |=> !host_rdata[0])
    else $error("underflow not cleared");
  code_live_a: assert property (host_rd && host_addr == 8'h04
    && code_detect == $past(code_detect) && code_detect == $past(code_detect, 2)
    |=> host_rdata[6] == $past(code_detect))
    else $error("live detect wrong");
  code_latch_a: assert property (host_rd && host_addr == 8'h04 && code_detect
    && $past(code_detect) |=> host_rdata[7])
    else $error("latched detect missing");
  code_load_a: assert property (host_rd && host_addr == 8'h04 |=>
    host_rdata[5:0] == $past(code_reg))
    else $error("code field wrong");
  mask_rw_a: assert property (host_rd && host_addr == 8'h02 |=>
    host_rdata == $past(mask_reg))
    else $error("mask readback wrong");
  irq_mask_a: assert property (mask_reg == 8'h00 |-> !irq)
    else $error("irq while all masked");
  pkt_clear_a: assert property (host_rd && host_addr == 8'h03 && quiet ##1 quiet
    ##1 host_rd && host_addr == 8'h03 && quiet |=> host_rdata[7:4] == 4'h0)
    else $error("packet flags not cleared");
endmodule
bind fdlsm_regs fdlsm_regs_checker chk (
  .clk(clk), .arst_n(arst_n), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
  .host_wdata(host_wdata), .host_rdata(host_rdata), .irq(irq),
  .rx_bit_strobe(rx_bit_strobe), .rx_bit(rx_bit), .rx_byte_valid(rx_byte_valid),
  .rx_byte(rx_byte), .rx_byte_first(rx_byte_first), .rx_byte_last(rx_byte_last),
  .rx_crc_ok(rx_crc_ok), .code_detect(code_detect), .code_valid(code_valid),
  .code_word(code_word), .tx_fifo_empty(tx_fifo_empty), .tx_fifo_full(tx_fifo_full),
  .tx_fifo_half_empty(tx_fifo_half_empty), .tx_in_message(tx_in_message),
  .tx_byte_req(tx_byte_req), .tx_msg_done(tx_msg_done), .tx_abort(tx_abort));
`default_nettype wire

// [fdlsm_host.sv]
// Host processor model on the parallel control port
`timescale 1ns/1ps
`default_nettype none
module fdlsm_host (
  // Clock
  input  wire logic       clk,
  // Control port
  output logic      [7:0] host_addr,
  output logic            host_wr,
  output logic            host_rd,
  output logic      [7:0] host_wdata,
  input  wire logic [7:0] host_rdata
);
  initial begin
    host_addr = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge clk);
    #2;
    host_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #2;
    host_addr = a;
    host_rd = 1'b1;
    @(posedge clk);
    #2;
    d = host_rdata;
    host_rd = 1'b0;
    // Unassigned transmit status bits are not trusted
    if (a == 8'h06) d = d & 8'h07;
  endtask
endmodule
`default_nettype wire

// [fdlsm_regs_tb.sv]
// Self-checking bench for the data-link status register set
`timescale 1ns/1ps
`default_nettype none
module fdlsm_regs_tb
  import fdlsm_pkg::*;
();
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] host_addr, host_wdata, host_rdata, d;
  logic       host_wr, host_rd, irq, tx_abort;
  logic       rx_bit_strobe = 1'b0;
  logic       rx_bit = 1'b0;
  logic       rx_byte_valid = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic       rx_byte_first = 1'b0;
  logic       rx_byte_last = 1'b0;
  logic       rx_crc_ok = 1'b0;
  logic       code_detect = 1'b0;
  logic       code_valid = 1'b0;
  logic [5:0] code_word = 6'h00;
  logic       tx_fifo_empty = 1'b0;
  logic       tx_fifo_full = 1'b0;
  logic       tx_fifo_half_empty = 1'b0;
  logic       tx_in_message = 1'b0;
  logic       tx_byte_req = 1'b0;
  logic       tx_msg_done = 1'b0;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  fdlsm_regs #(.RX_DEPTH(16)) DUT (
    .clk(clk), .arst_n(arst_n), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .irq(irq),
    .rx_bit_strobe(rx_bit_strobe), .rx_bit(rx_bit), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .rx_byte_first(rx_byte_first), .rx_byte_last(rx_byte_last),
    .rx_crc_ok(rx_crc_ok), .code_detect(code_detect), .code_valid(code_valid),
    .code_word(code_word), .tx_fifo_empty(tx_fifo_empty), .tx_fifo_full(tx_fifo_full),
    .tx_fifo_half_empty(tx_fifo_half_empty), .tx_in_message(tx_in_message),
    .tx_byte_req(tx_byte_req), .tx_msg_done(tx_msg_done), .tx_abort(tx_abort));
  fdlsm_host h (.clk(clk), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata));
  always #25 clk = ~clk;
  task automatic wrap_up();
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    h.rd(a, d);
    chk($sformatf("reg %h", a), d & m, e);
  endtask
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  task automatic push(input logic [7:0] b, input logic f, input logic l, input logic ok);
    tick();
    rx_byte = b;
    rx_byte_first = f;
    rx_byte_last = l;
    rx_crc_ok = ok;
    rx_byte_valid = 1'b1;
    tick();
    rx_byte_valid = 1'b0;
  endtask
  // Sends n ones then a zero
  task automatic bits(input int n);
    for (int i = 0; i <= n; i++) begin
      tick();
      rx_bit_strobe = 1'b1;
      rx_bit = (i < n);
      tick();
      rx_bit_strobe = 1'b0;
    end
  endtask
  task automatic t_reset();
    rdc(8'h02, 8'hFF, 8'h00);
    rdc(8'h04, 8'h3F, 8'h3F);
    rdc(8'h03, 8'hFF, 8'h08);
    chk("irq", {7'h00, irq}, 8'h00);
  endtask
  task automatic t_mask();
    for (int i = 0; i < 8; i++) begin
      h.wr(8'h02, 8'h01 << i);
      rdc(8'h02, 8'hFF, 8'h01 << i);
    end
    h.wr(8'h06, 8'hFF);
    rdc(8'h02, 8'hFF, 8'h80);
    rdc(8'h07, 8'hFF, 8'h00);
  endtask
  task automatic t_packet();
    h.wr(8'h02, 8'h08);
    chk("irq", {7'h00, irq}, 8'h00);
    push(8'hAA, 1'b1, 1'b0, 1'b1);
    chk("irq", {7'h00, irq}, 8'h01);
    push(8'h55, 1'b0, 1'b0, 1'b1);
    push(8'hC3, 1'b0, 1'b1, 1'b1);
    rdc(8'h01, 8'h68, 8'h68);
    rdc(8'h01, 8'h60, 8'h00);
    rdc(8'h03, 8'hFF, 8'h11);
    rdc(8'h05, 8'hFF, 8'hAA);
    rdc(8'h03, 8'hFF, 8'h00);
    rdc(8'h05, 8'hFF, 8'h55);
    rdc(8'h03, 8'hFF, 8'h06);
    rdc(8'h05, 8'hFF, 8'hC3);
    rdc(8'h03, 8'hFF, 8'h08);
    chk("irq", {7'h00, irq}, 8'h00);
  endtask
  task automatic t_bad();
    push(8'h11, 1'b1, 1'b0, 1'b1);
    push(8'h22, 1'b0, 1'b1, 1'b0);
    rdc(8'h03, 8'hFF, 8'h51);
    rdc(8'h05, 8'hFF, 8'h11);
    rdc(8'h03, 8'hFF, 8'h02);
    rdc(8'h05, 8'hFF, 8'h22);
  endtask
  task automatic t_abort();
    bits(6);
    rdc(8'h03, 8'h80, 8'h00);
    bits(7);
    rdc(8'h03, 8'h80, 8'h80);
    rdc(8'h03, 8'h80, 8'h00);
  endtask
  task automatic t_ovr();
    for (int i = 0; i <= 16; i++) push(i[7:0], i == 0, 1'b0, 1'b1);
    rdc(8'h03, 8'h28, 8'h20);
    rdc(8'h01, 8'h1E, 8'h1A);
    for (int i = 0; i < 16; i++) rdc(8'h05, 8'hFF, i[7:0]);
    rdc(8'h03, 8'h08, 8'h08);
    rdc(8'h01, 8'h18, 8'h00);
  endtask
  task automatic t_code();
    code_detect = 1'b1;
    code_word = 6'h2D;
    code_valid = 1'b1;
    tick();
    code_valid = 1'b0;
    rdc(8'h04, 8'hFF, 8'hED);
    rdc(8'h01, 8'h80, 8'h80);
    code_detect = 1'b0;
    rdc(8'h04, 8'hC0, 8'h80);
    rdc(8'h04, 8'hC0, 8'h00);
    rdc(8'h01, 8'h80, 8'h80);
  endtask
  // Reset in mid-run must reload the code field and the mask
  task automatic t_rst2();
    tick();
    arst_n = 1'b0;
    tick();
    tick();
    arst_n = 1'b1;
    rdc(8'h04, 8'hFF, 8'h3F);
    rdc(8'h02, 8'hFF, 8'h00);
    rdc(8'h03, 8'hFF, 8'h08);
  endtask
  task automatic t_tx();
    tx_fifo_half_empty = 1'b1;
    h.wr(8'h02, 8'h04);
    chk("irq", {7'h00, irq}, 8'h01);
    rdc(8'h01, 8'h06, 8'h06);
    tx_fifo_half_empty = 1'b0;
    tick();
    chk("irq", {7'h00, irq}, 8'h00);
    tx_fifo_empty = 1'b1;
    rdc(8'h06, 8'hFF, 8'h04);
    tx_fifo_empty = 1'b0;
    tx_fifo_full = 1'b1;
    rdc(8'h06, 8'hFF, 8'h02);
    tx_fifo_full = 1'b0;
    tx_fifo_empty = 1'b1;
    tx_in_message = 1'b1;
    tx_byte_req = 1'b1;
    tick();
    tx_byte_req = 1'b0;
    chk("tx_abort", {7'h00, tx_abort}, 8'h01);
    tick();
    chk("tx_abort", {7'h00, tx_abort}, 8'h00);
    rdc(8'h06, 8'hFF, 8'h05);
    rdc(8'h06, 8'hFF, 8'h04);
    tx_msg_done = 1'b1;
    tick();
    tx_msg_done = 1'b0;
    rdc(8'h01, 8'h01, 8'h01);
    rdc(8'h01, 8'h01, 8'h00);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #2;
    arst_n = 1'b1;
    t_reset();
    t_mask();
    t_packet();
    t_bad();
    t_abort();
    t_ovr();
    t_code();
    t_rst2();
    t_tx();
    wrap_up();
  end
endmodule
`default_nettype wire
